// ---- rtl/bcrcr_pkg.sv ----
package bcrcr_pkg;
  // Printed offsets are not multiples of four: they are indices
  localparam logic [7:0] IDX_MEM_IO_ILIM = 8'h9a;
  localparam logic [7:0] IDX_PERI_PRO_ILIM = 8'h9b;
  localparam logic [7:0] IDX_CORE_ILIM = 8'h9c;
  localparam logic [7:0] IDX_CORE2_CONF = 8'h9d;
  localparam logic [7:0] IDX_CORE1_CONF = 8'h9e;
  localparam int ADDR_W = 12;
  // Limit code to milliamps
  localparam logic [11:0] BASE_HIGH_MA = 12'h5dc;
  localparam logic [11:0] BASE_LOW_MA = 12'h1f4;
  localparam logic [11:0] STEP_MA = 12'h064;
  // Field positions
  localparam int HI_LSB = 4;
  localparam int MODE_LSB = 6;
  localparam int PD_BIT = 5;
  // Writable bits of the config registers; 4:3 reserved
  localparam logic [7:0] CONF_WMASK = 8'he7;
  localparam logic [7:0] ILIM_RST = 8'h00;
  localparam logic [7:0] CONF_RST = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    BCRCR_MODE_AB = 2'b00,
    BCRCR_MODE_SLEEP = 2'b01,
    BCRCR_MODE_SYNC = 2'b10,
    BCRCR_MODE_AUTO = 2'b11
  } bcrcr_mode_t;
endpackage

// ---- rtl/bcrcr_regs.sv ----
// Notes on behaviour
// - 0x9a: memory limit 7:4, IO limit 3:0, each 1500 mA plus 100 per step.
// - When merged, the memory-buck limit applied is twice its decoded value.
// - 0x9b bits 7:4 hold the peripheral limit, 1500 mA plus 100 per step.
// - 0x9b 3:0 is the processor limit, 500 mA+100/step, x2 at full current.
// - 0x9c 7:4 is the second core limit, 500 mA+100/step, x2 at full current.
// - 0x9c 3:0 is the first core limit, 500 mA+100/step, x2 at full current.
// - 0x9d bits 7:6 pick second core mode: A/B, sleep, sync, automatic.
// - 0x9e bits 7:6 pick first core mode with the same encoding.
// - 0x9d bit 5 clear enables the off-state pull-down, except in dual phase.
// - 0x9e bit 5 clear enables the first core pull-down, set removes it.
// - 0x9d 2:0 pick own output, core or peripheral switch; 000 invalid.
// - 0x9e bits 2:0 choose first core feedback sources in any combination.
// - First sense 000 turns the mixer off; merged it senses differentially.
module bcrcr_regs
  import bcrcr_pkg::*;
(
  input wire logic clk, // 10 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic merged_operation, // Memory and IO bucks merged
  input wire logic core_bucks_merged, // Core bucks dual phase
  input wire logic pro_full_current, // Processor buck full current
  input wire logic core2_full_current, // Second core full current
  input wire logic core1_full_current, // First core full current
  output logic [12:0] memory_buck_limit_ma, // Applied limit, mA
  output logic [11:0] io_buck_limit_ma, // Applied limit, mA
  output logic [11:0] peripheral_buck_limit_ma, // Applied limit, mA
  output logic [11:0] processor_buck_limit_ma, // Applied limit, mA
  output logic [11:0] second_core_limit_ma, // Applied limit, mA
  output logic [11:0] first_core_limit_ma, // Applied limit, mA
  output logic [1:0] second_core_op_mode, // Mode select
  output logic [1:0] first_core_op_mode, // Mode select
  output logic second_core_pulldown_en, // Pull-down when disabled
  output logic first_core_pulldown_en, // Pull-down when disabled
  output logic [2:0] second_core_sense_select, // Feedback sources
  output logic [2:0] first_core_sense_select, // Feedback sources
  output logic second_core_sense_invalid, // Sense field is 000
  output logic first_core_mixer_off, // Sense mixer disabled
  output logic first_core_diff_sense // Merged differential sense
);
  // Whole block state in one word: one comb copy, one register
  typedef struct packed {
    logic [7:0] mem_io_buck_current_limit_reg;
    logic [7:0] peri_pro_buck_current_limit_reg;
    logic [7:0] core_bucks_current_limit_reg;
    logic [7:0] second_core_buck_config_reg;
    logic [7:0] first_core_buck_config_reg;
    logic aw_hold_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_hold_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic awready_reg;
    logic wready_reg;
    logic arready_reg;
    logic [12:0] mem_ma_reg;
    logic [11:0] io_ma_reg;
    logic [11:0] peri_ma_reg;
    logic [11:0] pro_ma_reg;
    logic [11:0] core2_ma_reg;
    logic [11:0] core1_ma_reg;
    logic [1:0] core2_mode_reg;
    logic [1:0] core1_mode_reg;
    logic core2_pd_reg;
    logic core1_pd_reg;
    logic [2:0] core2_sense_reg;
    logic [2:0] core1_sense_reg;
    logic core2_sense_bad_reg;
    logic mixer_off_reg;
    logic diff_sense_reg;
  } bcrcr_state_t;

  bcrcr_state_t st_reg, st_next;

  function automatic logic [11:0] limit_ma(input logic [11:0] base,
                                           input logic [3:0] code,
                                           input logic dbl);
    logic [11:0] ma;
    ma = base + 12'(code) * STEP_MA;
    limit_ma = dbl ? 12'(ma << 1) : ma;
  endfunction

  function automatic logic [7:0] merged_operation_byte(input logic [7:0] old,
                                            input logic [7:0] data,
                                            input logic strb,
                                            input logic [7:0] mask);
    merged_operation_byte = strb ? ((data & mask) | (old & ~mask)) : old;
  endfunction

  // Index from byte address; low two bits ignored
  function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction

  logic do_write, do_read;
  logic [9:0] widx, ridx;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  always_comb begin
    st_next = st_reg;
    wa = st_reg.aw_hold_reg ? st_reg.aw_addr_reg : s_axi_awaddr;
    wd = st_reg.w_hold_reg ? st_reg.w_data_reg : s_axi_wdata;
    ws = st_reg.w_hold_reg ? st_reg.w_strb_reg : s_axi_wstrb;
    widx = word_idx(wa);
    ridx = word_idx(s_axi_araddr);
    // Address and data taken independently, either order
    if (s_axi_awvalid && !st_reg.aw_hold_reg && !st_reg.bvalid_reg) begin
      st_next.aw_hold_reg = 1'b1;
      st_next.aw_addr_reg = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_hold_reg && !st_reg.bvalid_reg) begin
      st_next.w_hold_reg = 1'b1;
      st_next.w_data_reg = s_axi_wdata;
      st_next.w_strb_reg = s_axi_wstrb;
    end
    do_write = (st_reg.aw_hold_reg || s_axi_awvalid)
      && (st_reg.w_hold_reg || s_axi_wvalid) && !st_reg.bvalid_reg;
    if (do_write) begin
      st_next.aw_hold_reg = 1'b0;
      st_next.w_hold_reg = 1'b0;
      st_next.bvalid_reg = 1'b1;
      st_next.bresp_reg = RESP_OKAY;
      unique case (widx)
        10'(IDX_MEM_IO_ILIM): begin
          st_next.mem_io_buck_current_limit_reg = merged_operation_byte(
            st_reg.mem_io_buck_current_limit_reg, wd[7:0], ws[0], 8'hff);
        end
        10'(IDX_PERI_PRO_ILIM): begin
          st_next.peri_pro_buck_current_limit_reg = merged_operation_byte(
            st_reg.peri_pro_buck_current_limit_reg, wd[7:0], ws[0], 8'hff);
        end
        10'(IDX_CORE_ILIM): begin
          st_next.core_bucks_current_limit_reg = merged_operation_byte(
            st_reg.core_bucks_current_limit_reg, wd[7:0], ws[0], 8'hff);
        end
        10'(IDX_CORE2_CONF): begin
          st_next.second_core_buck_config_reg = merged_operation_byte(
            st_reg.second_core_buck_config_reg, wd[7:0], ws[0], CONF_WMASK);
        end
        10'(IDX_CORE1_CONF): begin
          st_next.first_core_buck_config_reg = merged_operation_byte(
            st_reg.first_core_buck_config_reg, wd[7:0], ws[0], CONF_WMASK);
        end
        default: begin
          st_next.bresp_reg = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid_reg && s_axi_bready) begin
      st_next.bvalid_reg = 1'b0;
    end
    do_read = s_axi_arvalid && !st_reg.rvalid_reg;
    if (do_read) begin
      st_next.rvalid_reg = 1'b1;
      st_next.rresp_reg = RESP_OKAY;
      st_next.rdata_reg = 32'h0;
      unique case (ridx)
        10'(IDX_MEM_IO_ILIM):
          st_next.rdata_reg[7:0] = st_reg.mem_io_buck_current_limit_reg;
        10'(IDX_PERI_PRO_ILIM):
          st_next.rdata_reg[7:0] = st_reg.peri_pro_buck_current_limit_reg;
        10'(IDX_CORE_ILIM):
          st_next.rdata_reg[7:0] = st_reg.core_bucks_current_limit_reg;
        10'(IDX_CORE2_CONF):
          st_next.rdata_reg[7:0] = st_reg.second_core_buck_config_reg;
        10'(IDX_CORE1_CONF):
          st_next.rdata_reg[7:0] = st_reg.first_core_buck_config_reg;
        default: begin
          st_next.rresp_reg = RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid_reg && s_axi_rready) begin
      st_next.rvalid_reg = 1'b0;
    end

    // decoded controls follow stored fields every cycle
    // memory limit doubles when merged
    // Top code doubled no longer fits 12 bits, hence the extra bit
    st_next.mem_ma_reg = {1'b0, limit_ma(BASE_HIGH_MA,
      st_reg.mem_io_buck_current_limit_reg[HI_LSB+:4], 1'b0)}
      << merged_operation;
    st_next.io_ma_reg = limit_ma(BASE_HIGH_MA,
      st_reg.mem_io_buck_current_limit_reg[3:0], 1'b0);
    st_next.peri_ma_reg = limit_ma(BASE_HIGH_MA,
      st_reg.peri_pro_buck_current_limit_reg[HI_LSB+:4], 1'b0);
    st_next.pro_ma_reg = limit_ma(BASE_LOW_MA,
      st_reg.peri_pro_buck_current_limit_reg[3:0], pro_full_current);
    st_next.core2_ma_reg = limit_ma(BASE_LOW_MA,
      st_reg.core_bucks_current_limit_reg[HI_LSB+:4], core2_full_current);
    st_next.core1_ma_reg = limit_ma(BASE_LOW_MA,
      st_reg.core_bucks_current_limit_reg[3:0], core1_full_current);
    st_next.core2_mode_reg =
      st_reg.second_core_buck_config_reg[MODE_LSB+:2];
    st_next.core1_mode_reg =
      st_reg.first_core_buck_config_reg[MODE_LSB+:2];
    st_next.core2_pd_reg = !st_reg.second_core_buck_config_reg[PD_BIT]
      && !core_bucks_merged;
    st_next.core1_pd_reg = !st_reg.first_core_buck_config_reg[PD_BIT];
    st_next.core2_sense_reg = st_reg.second_core_buck_config_reg[2:0];
    st_next.core2_sense_bad_reg =
      st_reg.second_core_buck_config_reg[2:0] == 3'h0;
    st_next.core1_sense_reg = st_reg.first_core_buck_config_reg[2:0];
    // mixer off on 000; merged selects differential sensing
    st_next.mixer_off_reg = st_reg.first_core_buck_config_reg[2:0] == 3'h0;
    st_next.diff_sense_reg =
      (st_reg.first_core_buck_config_reg[2:0] == 3'h0) && core_bucks_merged;
    // Readies taken from the next state so they leave straight from flops
    st_next.awready_reg = !st_next.aw_hold_reg && !st_next.bvalid_reg;
    st_next.wready_reg = !st_next.w_hold_reg && !st_next.bvalid_reg;
    st_next.arready_reg = !st_next.rvalid_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.second_core_buck_config_reg <= CONF_RST;
      st_reg.first_core_buck_config_reg <= CONF_RST;
      st_reg.mem_io_buck_current_limit_reg <= ILIM_RST;
      st_reg.peri_pro_buck_current_limit_reg <= ILIM_RST;
      st_reg.core_bucks_current_limit_reg <= ILIM_RST;
      st_reg.mem_ma_reg <= {1'b0, BASE_HIGH_MA};
      st_reg.io_ma_reg <= BASE_HIGH_MA;
      st_reg.peri_ma_reg <= BASE_HIGH_MA;
      st_reg.pro_ma_reg <= BASE_LOW_MA;
      st_reg.core2_ma_reg <= BASE_LOW_MA;
      st_reg.core1_ma_reg <= BASE_LOW_MA;
      st_reg.core2_sense_reg <= 3'h1;
      st_reg.core1_sense_reg <= 3'h1;
      st_reg.core2_pd_reg <= 1'b1;
      st_reg.core1_pd_reg <= 1'b1;
      st_reg.awready_reg <= 1'b1;
      st_reg.wready_reg <= 1'b1;
      st_reg.arready_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Ready is high only while a channel can be accepted this cycle
  assign s_axi_awready = st_reg.awready_reg;
  assign s_axi_wready = st_reg.wready_reg;
  assign s_axi_arready = st_reg.arready_reg;
  assign s_axi_bvalid = st_reg.bvalid_reg;
  assign s_axi_bresp = st_reg.bresp_reg;
  assign s_axi_rvalid = st_reg.rvalid_reg;
  assign s_axi_rdata = st_reg.rdata_reg;
  assign s_axi_rresp = st_reg.rresp_reg;
  assign memory_buck_limit_ma = st_reg.mem_ma_reg;
  assign io_buck_limit_ma = st_reg.io_ma_reg;
  assign peripheral_buck_limit_ma = st_reg.peri_ma_reg;
  assign processor_buck_limit_ma = st_reg.pro_ma_reg;
  assign second_core_limit_ma = st_reg.core2_ma_reg;
  assign first_core_limit_ma = st_reg.core1_ma_reg;
  assign second_core_op_mode = st_reg.core2_mode_reg;
  assign first_core_op_mode = st_reg.core1_mode_reg;
  assign second_core_pulldown_en = st_reg.core2_pd_reg;
  assign first_core_pulldown_en = st_reg.core1_pd_reg;
  assign second_core_sense_select = st_reg.core2_sense_reg;
  assign first_core_sense_select = st_reg.core1_sense_reg;
  assign second_core_sense_invalid = st_reg.core2_sense_bad_reg;
  assign first_core_mixer_off = st_reg.mixer_off_reg;
  assign first_core_diff_sense = st_reg.diff_sense_reg;
endmodule

// ---- test/bcrcr_regs_assertions.sv ----
module bcrcr_regs_assertions (
  input wire logic clk, // Block clock
  input wire logic rst, // Sync reset, high
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic merged_operation, // Memory and IO merged
  input wire logic pro_full_current, // Processor full current
  input wire logic core_bucks_merged, // Core dual phase
  input wire logic [12:0] memory_buck_limit_ma, // Memory limit
  input wire logic [11:0] processor_buck_limit_ma, // Processor limit
  input wire logic [1:0] first_core_op_mode, // First core mode
  input wire logic second_core_pulldown_en, // Second pull-down
  input wire logic second_core_sense_invalid, // Second sense 000
  input wire logic first_core_mixer_off, // Mixer disabled
  input wire logic first_core_diff_sense, // Differential sense
  input wire logic [2:0] second_core_sense_select, // Second sources
  input wire logic [2:0] first_core_sense_select // First sources
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A write landing in the same cycle would mask the doubling
  a_mem_double: assert property (
    $rose(merged_operation) && !$rose(s_axi_bvalid) |=>
    {1'b0, memory_buck_limit_ma} == {$past(memory_buck_limit_ma), 1'b0})
    else $error("memory limit not doubled when merged");
  a_pro_double: assert property (
    $rose(pro_full_current) && !$rose(s_axi_bvalid) |=>
    {1'b0, processor_buck_limit_ma} == {$past(processor_buck_limit_ma), 1'b0})
    else $error("processor limit not doubled at full current");
  a_pd_merged: assert property (
    core_bucks_merged |=> !second_core_pulldown_en)
    else $error("second pull-down active while merged");
  a_diff_sense: assert property (
    first_core_diff_sense ==
    (first_core_mixer_off && $past(core_bucks_merged)))
    else $error("differential sense flag wrong");
  a_sense_bad: assert property (
    second_core_sense_invalid == (second_core_sense_select == 3'h0))
    else $error("invalid sense flag wrong");
  a_mixer_off: assert property (
    first_core_mixer_off == (first_core_sense_select == 3'h0))
    else $error("mixer off flag wrong");
  a_mode_hold: assert property (
    !$rose(s_axi_bvalid) |=> $stable(first_core_op_mode))
    else $error("mode changed without a write");
  a_write_ans: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  a_bresp_wait: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_wait: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cover property ($rose(merged_operation));
  cover property (first_core_diff_sense);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind bcrcr_regs bcrcr_regs_assertions chk_u (.*);

// ---- test/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bcrcr_pkg::*;
  logic clk = '0, rst = '1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, merged_operation = '0;
  logic core_bucks_merged = '0, pro_full_current = '0;
  logic core2_full_current = '0, core1_full_current = '0;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  logic s_axi_rvalid, second_core_pulldown_en, first_core_pulldown_en;
  logic second_core_sense_invalid, first_core_mixer_off;
  logic first_core_diff_sense;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] second_core_op_mode, first_core_op_mode;
  logic [2:0] second_core_sense_select, first_core_sense_select;
  logic [12:0] memory_buck_limit_ma;
  logic [11:0] io_buck_limit_ma;
  logic [11:0] peripheral_buck_limit_ma, processor_buck_limit_ma;
  logic [11:0] second_core_limit_ma, first_core_limit_ma;
  int failures = 0, cmp_count = 0, cyc = 0;
  logic [31:0] seed = 32'h48e1, r;
  logic [7:0] v, u;
  logic [7:0] c [3] = '{3{8'h00}};
  logic [1:0] bq [$];
  logic [33:0] rq [$];

  bcrcr_regs dut_u (.*);

  initial forever #50 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(string n, logic [33:0] e, logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Wide sum so a doubled limit past 12 bits shows as a mismatch
  task automatic lv(string n, logic hi, logic [3:0] k, logic d,
                    logic [12:0] g);
    cmp(n, ({1'b0, hi ? BASE_HIGH_MA : BASE_LOW_MA} + STEP_MA * k) << d, g);
  endtask

  task automatic wr(logic [7:0] i, logic [7:0] d, logic [3:0] s,
                    logic [1:0] e);
    logic [31:0] q = xs();
    logic aw = 1'b1, w = 1'b1;
    bq.push_back(e);
    @(posedge clk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {q[31:8], d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (q[0]) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(logic [7:0] i, logic [33:0] e);
    logic [31:0] q = xs();
    rq.push_back(e);
    @(posedge clk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (q[0]) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic lims();
    lv("mem", 1, c[0][7:4], merged_operation, memory_buck_limit_ma);
    lv("io", 1, c[0][3:0], 1'b0, io_buck_limit_ma);
    lv("peri", 1, c[1][7:4], 1'b0, peripheral_buck_limit_ma);
    lv("pro", 0, c[1][3:0], pro_full_current, processor_buck_limit_ma);
    lv("core2", 0, c[2][7:4], core2_full_current, second_core_limit_ma);
    lv("core1", 0, c[2][3:0], core1_full_current, first_core_limit_ma);
  endtask

  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp("bresp", bq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready)
      cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(IDX_MEM_IO_ILIM + 8'(i), {RESP_OKAY, 24'h0, i < 3 ? 8'h00 : 8'h01});
    settle();
    lims();
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      r = xs();
      c = '{r[7:0], r[15:8], r[23:16]};
      if (k == 0) c = '{8'hff, 8'hff, 8'hff};
      foreach (c[i]) wr(IDX_MEM_IO_ILIM + 8'(i), c[i], 4'hf, RESP_OKAY);
      {merged_operation, pro_full_current, core2_full_current,
        core1_full_current} <= k == 0 ? 4'hf : r[27:24];
      settle();
      lims();
      foreach (c[i])
        rd(IDX_MEM_IO_ILIM + 8'(i), {RESP_OKAY, 24'h0, c[i]});
    end
    $display("test limits done");
    for (int m = 0; m < 4; m++) begin
      r = xs();
      // Sense 000 both unmerged and merged, so the differential flag rises
      v = {m[1:0], r[5], 2'b11, m[0] == m[1] ? 3'h0 : r[2:0]};
      u = {~m[1:0], r[6], 2'b11, m == 1 ? 3'h0 : r[10:8]};
      wr(IDX_CORE1_CONF, v, 4'h1, RESP_OKAY);
      wr(IDX_CORE2_CONF, u, 4'h1, RESP_OKAY);
      core_bucks_merged <= m[0];
      settle();
      cmp("mode1", v[7:6], first_core_op_mode);
      cmp("mode2", u[7:6], second_core_op_mode);
      cmp("pd1", !v[5], first_core_pulldown_en);
      cmp("pd2", !u[5] && !m[0], second_core_pulldown_en);
      cmp("sense1", v[2:0], first_core_sense_select);
      cmp("sense2", u[2:0], second_core_sense_select);
      cmp("inval2", u[2:0] == 3'h0, second_core_sense_invalid);
      cmp("mix", v[2:0] == 3'h0, first_core_mixer_off);
      cmp("diff", v[2:0] == 3'h0 && m[0], first_core_diff_sense);
      rd(IDX_CORE1_CONF, {RESP_OKAY, 24'h0, v & 8'he7});
      rd(IDX_CORE2_CONF, {RESP_OKAY, 24'h0, u & 8'he7});
    end
    $display("test config done");
    // Strobe off must leave the register untouched
    wr(IDX_CORE1_CONF, ~v, 4'h0, RESP_OKAY);
    rd(IDX_CORE1_CONF, {RESP_OKAY, 24'h0, v & 8'he7});
    wr(8'h99, 8'hff, 4'hf, RESP_SLVERR);
    rd(8'h9f, {RESP_SLVERR, 32'h0});
    settle();
    $display("test errors done");
    test_done();
  end
endmodule
